// >>> design/ppp_pkg.sv
package ppp_pkg;
  localparam int unsigned CLK_HZ      = 20000000;
  // Clamp deglitch time in microseconds
  localparam int unsigned DEGLITCH_US = 10;
  localparam logic [15:0] DEGLITCH_CYC = 16'((CLK_HZ / 1000000) * DEGLITCH_US);
  // Supply good debounce, cycles
  localparam logic [7:0]  POR_GOOD_CYC = 8'h10;
  // Hard reset pulse length, cycles
  localparam logic [7:0]  HRST_CYC     = 8'h20;
  localparam int unsigned NPORT        = 2;
  // Fault flag bit positions
  localparam int unsigned F_CLAMP = 0;
  localparam int unsigned F_OCP   = 1;
  localparam int unsigned F_OVP   = 2;
  localparam int unsigned F_UVP   = 3;
  localparam int unsigned F_RCP   = 4;
  localparam int unsigned NFLT    = 5;
  localparam logic [4:0]  FLT_RST = 5'h00;

  typedef enum logic [2:0] {
    PPP_SUP_OFF  = 3'b001,
    PPP_SUP_BUS  = 3'b010,
    PPP_SUP_MAIN = 3'b100
  } ppp_sup_e;
endpackage

// >>> design/ppp_path.sv
module ppp_path (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_b,
  input  wire logic                     i_ce,
  input  wire logic                     i_en,
  input  wire logic                     i_source,
  input  wire logic                     i_clamp_exceeded,
  input  wire logic                     i_ocp_trip,
  input  wire logic                     i_ov,
  input  wire logic                     i_uv,
  input  wire logic                     i_rev,
  input  wire logic                     i_clear,
  output logic                          o_sw_on,
  output logic                          o_clamp_arm,
  output logic                          o_rcp_comparator,
  output logic                          o_ext_en,
  output logic [ppp_pkg::NFLT-1:0]      o_flags
);
  logic [15:0]               cnt;
  logic [15:0]               next_cnt;
  logic [ppp_pkg::NFLT-1:0]  flags;
  logic [ppp_pkg::NFLT-1:0]  next_flags;
  logic [ppp_pkg::NFLT-1:0]  trip;
  logic                      clamp_act;

  always_comb begin
    clamp_act = i_en && i_source && i_clamp_exceeded; // R7
    next_cnt  = clamp_act ? ((cnt == 16'hFFFF) ? cnt : cnt + 16'h0001) : 16'h0000;
    trip                   = '0;
    trip[ppp_pkg::F_CLAMP] = clamp_act && (cnt >= ppp_pkg::DEGLITCH_CYC); // R8
    trip[ppp_pkg::F_OCP]   = i_en && i_ocp_trip; // R9
    trip[ppp_pkg::F_OVP]   = i_en && i_ov; // R10
    trip[ppp_pkg::F_UVP]   = i_en && i_uv; // R10
    trip[ppp_pkg::F_RCP]   = i_en && i_rev; // R12
    // Set wins over clear
    next_flags = (i_clear ? '0 : flags) | trip; // R17
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt   <= 16'h0000;
      flags <= ppp_pkg::FLT_RST;
    end else if (i_ce) begin
      cnt   <= next_cnt;
      flags <= next_flags;
    end
  end

  assign o_flags          = flags;
  // Latched off until firmware clears
  assign o_sw_on          = i_en && (flags == '0) && (trip == '0); // R16
  assign o_clamp_arm      = i_en && i_source; // R7
  assign o_rcp_comparator = i_source; // R11
  // Only voltage faults drop the external path
  assign o_ext_en = i_en && !flags[ppp_pkg::F_OVP] && !flags[ppp_pkg::F_UVP]
                    && !i_ov && !i_uv; // R14 R15
endmodule

// >>> design/ppp_ctrl.sv
// Functional notes
// R1: Core power comes from the main supply whenever it is good, else from the bus.
// R2: Bus to main switchover happens on its own without a reset.
// R3: Losing main supply below its threshold while on main with bus present issues a hard reset.
// R4: Each supply must be judged good by its own debounced power-on check before use.
// R5: The bus regulator runs only while the main supply is absent.
// R6: Each switch is configured as sink or source independently.
// R7: The overcurrent clamp is armed only on a source path, at a firmware-set level.
// R8: A clamp event lasting beyond the deglitch time latches the switch off.
// R9: A forward-drop trip latches the switch off at once.
// R10: Over- or under-voltage on a port's bus disables its path.
// R11: Source paths use comparator reverse protection, sinks use ideal-diode mode.
// R12: A flagged reverse current turns the switch off in either mode.
// R13: External path controls drive high to enable their paths.
// R14: Over- or under-voltage drops the external path controls.
// R15: Overcurrent and thermal events leave the external path controls alone.
// R16: A tripped switch stays off until firmware clears and re-enables it; the code turns it back on at the clear alone while i_path_en stays high.
// R17: Each trip sets a sticky per-port cause flag.
module ppp_ctrl (
  input  wire logic                                i_clk,
  input  wire logic                                i_rst_b,
  input  wire logic                                i_ce,
  input  wire logic                                i_main_supply_input,
  input  wire logic                                i_main_below_thr,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_vbus_present,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_path_en,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_path_source,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_ext_cfg,
  input  wire logic [ppp_pkg::NPORT*2-1:0]         i_clamp_current_level,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_clamp_exceeded,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_trip_current_level,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_ov,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_uv,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_rev,
  input  wire logic [ppp_pkg::NPORT-1:0]           i_fault_clear,
  output logic                                     o_core_from_main,
  output logic                                     o_core_from_bus,
  output logic                                     o_bus_ldo_en,
  output logic                                     o_hard_reset,
  output logic [ppp_pkg::NPORT-1:0]                o_high_voltage_power_path_on,
  output logic [ppp_pkg::NPORT-1:0]                o_clamp_arm,
  output logic [ppp_pkg::NPORT*2-1:0]              o_clamp_level,
  output logic [ppp_pkg::NPORT-1:0]                o_rcp_comparator,
  output logic                                     o_ext_path_ctrl_a,
  output logic                                     o_ext_path_ctrl_b,
  output logic [ppp_pkg::NPORT*ppp_pkg::NFLT-1:0]  o_fault_flags
);
  // Two-flop synchronisers for the analog comparator levels
  localparam int unsigned NS = 3 + 5 * ppp_pkg::NPORT;
  logic [NS-1:0] s1;
  logic [NS-1:0] s2;
  logic [NS-1:0] next_s1;
  always_comb begin
    next_s1 = {i_main_supply_input, i_main_below_thr, |i_vbus_present,
               i_clamp_exceeded, i_trip_current_level, i_ov, i_uv, i_rev};
  end
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      s1 <= '0;
      s2 <= '0;
    end else if (i_ce) begin
      s1 <= next_s1;
      s2 <= s1;
    end
  end
  logic                         main_raw;
  logic                         main_low;
  logic                         bus_raw;
  logic [ppp_pkg::NPORT-1:0]    clx;
  logic [ppp_pkg::NPORT-1:0]    ocx;
  logic [ppp_pkg::NPORT-1:0]    ovx;
  logic [ppp_pkg::NPORT-1:0]    uvx;
  logic [ppp_pkg::NPORT-1:0]    rvx;
  assign {main_raw, main_low, bus_raw, clx, ocx, ovx, uvx, rvx} = s2;

  // Supply supervision and selection
  ppp_pkg::ppp_sup_e sup;
  ppp_pkg::ppp_sup_e next_sup;
  logic [7:0]        main_cnt;
  logic [7:0]        next_main_cnt;
  logic [7:0]        bus_cnt;
  logic [7:0]        next_bus_cnt;
  logic [7:0]        hr_cnt;
  logic [7:0]        next_hr_cnt;
  logic              main_good;
  logic              bus_good;

  always_comb begin
    next_main_cnt = (main_raw && !main_low) ?
                    ((main_cnt == ppp_pkg::POR_GOOD_CYC) ? main_cnt : main_cnt + 8'h01) : 8'h00; // R4
    next_bus_cnt  = bus_raw ?
                    ((bus_cnt == ppp_pkg::POR_GOOD_CYC) ? bus_cnt : bus_cnt + 8'h01) : 8'h00; // R4
    main_good     = (main_cnt == ppp_pkg::POR_GOOD_CYC);
    bus_good      = (bus_cnt == ppp_pkg::POR_GOOD_CYC);
    next_hr_cnt   = (hr_cnt != 8'h00) ? hr_cnt - 8'h01 : 8'h00;
    next_sup      = sup;
    case (sup)
      ppp_pkg::PPP_SUP_OFF: begin
        if (main_good) begin
          next_sup = ppp_pkg::PPP_SUP_MAIN; // R1
        end else if (bus_good) begin
          next_sup = ppp_pkg::PPP_SUP_BUS; // R5
        end
      end
      ppp_pkg::PPP_SUP_BUS: begin
        if (main_good) begin
          next_sup = ppp_pkg::PPP_SUP_MAIN; // R2
        end else if (!bus_good) begin
          next_sup = ppp_pkg::PPP_SUP_OFF;
        end
      end
      ppp_pkg::PPP_SUP_MAIN: begin
        if (!main_good) begin
          if (bus_good && main_low) begin
            next_sup    = ppp_pkg::PPP_SUP_BUS;
            next_hr_cnt = ppp_pkg::HRST_CYC; // R3
          end else if (bus_good) begin
            next_sup = ppp_pkg::PPP_SUP_BUS;
          end else begin
            next_sup = ppp_pkg::PPP_SUP_OFF;
          end
        end
      end
      default: next_sup = ppp_pkg::PPP_SUP_OFF;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      sup      <= ppp_pkg::PPP_SUP_OFF;
      main_cnt <= 8'h00;
      bus_cnt  <= 8'h00;
      hr_cnt   <= 8'h00;
    end else if (i_ce) begin
      sup      <= next_sup;
      main_cnt <= next_main_cnt;
      bus_cnt  <= next_bus_cnt;
      hr_cnt   <= next_hr_cnt;
    end
  end

  // Per-port protection
  logic [ppp_pkg::NPORT-1:0]               sw_on;
  logic [ppp_pkg::NPORT-1:0]               arm;
  logic [ppp_pkg::NPORT-1:0]               rcpc;
  logic [ppp_pkg::NPORT-1:0]               ext;
  logic [ppp_pkg::NPORT*ppp_pkg::NFLT-1:0] flg;
  for (genvar p = 0; p < ppp_pkg::NPORT; p++) begin : g_port
    ppp_path u_path (
      .i_clk            (i_clk),
      .i_rst_b          (i_rst_b),
      .i_ce             (i_ce),
      .i_en             (i_path_en[p]),
      .i_source         (i_path_source[p]), // R6
      .i_clamp_exceeded (clx[p]),
      .i_ocp_trip       (ocx[p]),
      .i_ov             (ovx[p]),
      .i_uv             (uvx[p]),
      .i_rev            (rvx[p]),
      .i_clear          (i_fault_clear[p]),
      .o_sw_on          (sw_on[p]),
      .o_clamp_arm      (arm[p]),
      .o_rcp_comparator (rcpc[p]),
      .o_ext_en         (ext[p]),
      .o_flags          (flg[p*ppp_pkg::NFLT +: ppp_pkg::NFLT])
    );
  end

  logic                                    next_core_from_main;
  logic                                    next_core_from_bus;
  logic                                    next_bus_ldo_en;
  logic                                    next_hard_reset;
  logic [ppp_pkg::NPORT-1:0]               next_hv_on;
  logic [ppp_pkg::NPORT-1:0]               next_clamp_arm;
  logic [ppp_pkg::NPORT*2-1:0]             next_clamp_level;
  logic [ppp_pkg::NPORT-1:0]               next_rcp_comparator;
  logic                                    next_ext_path_ctrl_a;
  logic                                    next_ext_path_ctrl_b;
  logic [ppp_pkg::NPORT*ppp_pkg::NFLT-1:0] next_fault_flags;

  // Selection follows the next supply state so it never lags the regulator enable on a switch between main and bus
  always_comb begin
    next_core_from_main  = (next_sup == ppp_pkg::PPP_SUP_MAIN); // R1
    next_core_from_bus   = (next_sup == ppp_pkg::PPP_SUP_BUS);
    next_bus_ldo_en      = !main_good && bus_raw; // R5
    next_hard_reset      = (hr_cnt != 8'h00); // R3
    next_hv_on           = sw_on & ~i_ext_cfg; // R9 R12 R16
    next_clamp_arm       = arm;
    next_clamp_level     = i_clamp_current_level; // R7
    next_rcp_comparator  = rcpc; // R11
    next_ext_path_ctrl_a = i_ext_cfg[0] && ext[0]; // R13
    next_ext_path_ctrl_b = i_ext_cfg[1] && ext[1]; // R13
    next_fault_flags     = flg;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_core_from_main             <= 1'b0;
      o_core_from_bus              <= 1'b0;
      o_bus_ldo_en                 <= 1'b0;
      o_hard_reset                 <= 1'b0;
      o_high_voltage_power_path_on <= '0;
      o_clamp_arm                  <= '0;
      o_clamp_level                <= '0;
      o_rcp_comparator             <= '0;
      o_ext_path_ctrl_a            <= 1'b0;
      o_ext_path_ctrl_b            <= 1'b0;
      o_fault_flags                <= '0;
    end else if (i_ce) begin
      o_core_from_main             <= next_core_from_main;
      o_core_from_bus              <= next_core_from_bus;
      o_bus_ldo_en                 <= next_bus_ldo_en;
      o_hard_reset                 <= next_hard_reset;
      o_high_voltage_power_path_on <= next_hv_on;
      o_clamp_arm                  <= next_clamp_arm;
      o_clamp_level                <= next_clamp_level;
      o_rcp_comparator             <= next_rcp_comparator;
      o_ext_path_ctrl_a            <= next_ext_path_ctrl_a;
      o_ext_path_ctrl_b            <= next_ext_path_ctrl_b;
      o_fault_flags                <= next_fault_flags;
    end
  end
endmodule

// >>> verif/ppp_ctrl_sva.sv
module ppp_ctrl_sva (
  input wire logic       i_clk,
  input wire logic       i_rst_b,
  input wire logic       i_ce,
  input wire logic [1:0] i_path_source,
  input wire logic [1:0] i_trip_current_level,
  input wire logic [1:0] i_ov,
  input wire logic [1:0] i_rev,
  input wire logic [1:0] i_fault_clear,
  input wire logic       o_core_from_main,
  input wire logic       o_core_from_bus,
  input wire logic       o_bus_ldo_en,
  input wire logic       o_hard_reset,
  input wire logic [1:0] o_high_voltage_power_path_on,
  input wire logic [1:0] o_clamp_arm,
  input wire logic       o_ext_path_ctrl_a,
  input wire logic [9:0] o_fault_flags
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_clk); endclocking
  // A frozen clock enable stalls every pipeline, so checks pause with it
  default disable iff (!i_rst_b || !i_ce);
  sequence ov3;
    i_ov[0] [*3];
  endsequence
  sequence hold8;
    o_hard_reset [*8];
  endsequence
  supply_excl_a: assert property (!(o_core_from_main && o_core_from_bus))
    else $error("both supplies selected");
  ldo_off_a: assert property (o_core_from_main |-> !o_bus_ldo_en)
    else $error("bus regulator on while on main");
  ov_switch_a: assert property (ov3 |=> !o_high_voltage_power_path_on[0])
    else $error("switch on during over-voltage");
  ov_ext_a: assert property (ov3 |=> !o_ext_path_ctrl_a)
    else $error("external path on during over-voltage");
  ocp_switch_a: assert property (i_trip_current_level[1] [*3] |=> !o_high_voltage_power_path_on[1])
    else $error("switch on during trip");
  rev_switch_a: assert property (i_rev[0] [*3] |=> !o_high_voltage_power_path_on[0])
    else $error("switch on during reverse current");
  flag_hold_a: assert property (o_fault_flags[2] && !i_fault_clear[0] && !$past(i_fault_clear[0]) |=> o_fault_flags[2])
    else $error("fault flag dropped without clear");
  arm_source_a: assert property (o_clamp_arm[1] |-> $past(i_path_source[1]) || $past(i_path_source[1], 2))
    else $error("clamp armed on sink path");
  hrst_len_a: assert property ($rose(o_hard_reset) |-> hold8 ##1 hold8 ##1 hold8 ##1 hold8 ##1 !o_hard_reset)
    else $error("hard reset pulse length wrong");
endmodule

bind ppp_ctrl ppp_ctrl_sva ppp_ctrl_sva_inst (.i_clk, .i_rst_b, .i_ce, .i_path_source, .i_trip_current_level, .i_ov,
  .i_rev, .i_fault_clear, .o_core_from_main, .o_core_from_bus, .o_bus_ldo_en, .o_hard_reset,
  .o_high_voltage_power_path_on, .o_clamp_arm, .o_ext_path_ctrl_a, .o_fault_flags);

// >>> verif/ppp_ana.sv
module ppp_ana (
  input  wire logic       i_main_on,
  input  wire logic [1:0] i_arm,
  input  wire logic [1:0] i_sel,
  input  wire logic [4:0] i_cause,
  output logic            o_main,
  output logic            o_below,
  output logic [1:0]      o_clamp,
  output logic [1:0]      o_trip,
  output logic [1:0]      o_ov,
  output logic [1:0]      o_uv,
  output logic [1:0]      o_rev
);
  timeunit 1ns;
  timeprecision 1ns;
  assign o_main  = i_main_on;
  assign o_below = !i_main_on;
  // Clamp only limits current, so only reports, while it is armed
  assign o_clamp = {2{i_cause[0]}} & i_sel & i_arm;
  assign o_trip  = {2{i_cause[1]}} & i_sel;
  assign o_ov    = {2{i_cause[2]}} & i_sel;
  assign o_uv    = {2{i_cause[3]}} & i_sel;
  assign o_rev   = {2{i_cause[4]}} & i_sel;
endmodule

// >>> verif/ppp_ctrl_test.sv
module ppp_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic       i_clk = 0, i_rst_b = 0, ce = 1, main_on = 0, mainin, below, cmain, cbus, ldo, hrst, exa, exb;
  logic [1:0] vbus = 0, en = 0, src = 0, ext = 0, clr = 0, sel = 0, arm, hv, clamp, trip, ov, uv, rev, rcp;
  logic [3:0] lvl = 0, olvl;
  logic [4:0] cause = 0;
  logic [9:0] flags;
  logic [7:0] seed = 8'h25;
  int         errors = 0, tests_run = 0, hr = 0, p, c, k, m;
  always #25 i_clk = ~i_clk;
  always @(posedge i_clk) if (hrst === 1'b1) hr++;
  ppp_ana ppp_ana_inst (.i_main_on(main_on), .i_arm(arm), .i_sel(sel), .i_cause(cause), .o_main(mainin),
    .o_below(below), .o_clamp(clamp), .o_trip(trip), .o_ov(ov), .o_uv(uv), .o_rev(rev));
  ppp_ctrl ppp_ctrl_inst (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(ce), .i_main_supply_input(mainin),
    .i_main_below_thr(below), .i_vbus_present(vbus), .i_path_en(en), .i_path_source(src), .i_ext_cfg(ext),
    .i_clamp_current_level(lvl), .i_clamp_exceeded(clamp), .i_trip_current_level(trip), .i_ov(ov), .i_uv(uv),
    .i_rev(rev), .i_fault_clear(clr), .o_core_from_main(cmain), .o_core_from_bus(cbus), .o_bus_ldo_en(ldo),
    .o_hard_reset(hrst), .o_high_voltage_power_path_on(hv), .o_clamp_arm(arm), .o_clamp_level(olvl),
    .o_rcp_comparator(rcp), .o_ext_path_ctrl_a(exa), .o_ext_path_ctrl_b(exb), .o_fault_flags(flags));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic logic ext_keeps(input int cz);
    return !(cz == ppp_pkg::F_OVP || cz == ppp_pkg::F_UVP);
  endfunction
  task automatic chk(input string n, input logic [9:0] e, input logic [9:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    cyc(20);
    i_rst_b <= 1;
    vbus <= 2'h3;
    cyc(10);
    chk("por_hold", 10'h0, 10'(cbus));
    for (k = 0; k < 80 && cbus !== 1'b1; k++) cyc(1);
    if (k == 80) errors++;
    chk("bus_sel", 10'h3, 10'({cmain, cbus, ldo}));
    main_on <= 1;
    for (k = 0; k < 80 && cmain !== 1'b1; k++) cyc(1);
    if (k == 80) errors++;
    chk("main_sel", 10'h4, 10'({cmain, cbus, ldo}));
    chk("no_hrst", 10'h0, 10'(hr));
    main_on <= 0;
    cyc(80);
    chk("hrst_len", 10'(ppp_pkg::HRST_CYC), 10'(hr));
    chk("bus_back", 10'h1, 10'(cbus));
    en <= 2'h3;
    for (m = 0; m < 2; m++) begin
      ext <= m ? 2'h3 : 2'h0;
      for (c = 0; c < 5; c++) begin
        seed = lfsr(seed);
        p = (c == 0 || c == 3) ? int'(seed[0]) : int'(c == 1);
        src <= seed[2:1] | (c == 0 ? 2'h3 : 2'h0);
        lvl <= seed[6:3];
        cyc(10);
        chk("pre_on", 10'h1, 10'(m ? (p ? exb : exa) : hv[p]));
        if (m == 0) chk("arm_rcp", 10'({src, src}), 10'({arm, rcp}));
        chk("level", 10'(lvl), 10'(olvl));
        sel <= 2'(1 << p);
        cause <= 5'(1 << c);
        cyc(260);
        chk("fault_out", 10'(m ? ext_keeps(c) : 1'b0), 10'(m ? (p ? exb : exa) : hv[p]));
        if (m == 0) chk("flags", 10'(1 << (p * 5 + c)), flags);
        cause <= 0;
        cyc(10);
        if (m == 0) chk("still_off", 10'h0, 10'(hv[p]));
        clr <= 2'h3;
        cyc(1);
        clr <= 0;
        cyc(10);
      end
    end
    ext <= 0;
    src <= 2'h3;
    sel <= 2'h1;
    cyc(10);
    cause <= 5'h01;
    cyc(150);
    cause <= 0;
    cyc(10);
    chk("short_clamp", 10'h1, 10'(hv[0]));
    ce <= 0;
    en <= 0;
    cyc(5);
    chk("ce_freeze", 10'h3, 10'(hv));
    ce <= 1;
    cyc(5);
    chk("ce_run", 10'h0, 10'(hv));
    summarize;
  end
endmodule
